// ### hdl/sru_regs.vh
`ifndef SRU_REGS_VH
`define SRU_REGS_VH
// Configuration register byte offsets
`define SRU_CTRL_OFS 8'h00
`define SRU_CFG_OFS 8'h04
`define SRU_STAT_OFS 8'h08
`define SRU_CLR_OFS 8'h0c
`define SRU_MASK_OFS 8'h10
`define SRU_CHEN_OFS 8'h14
`define SRU_TGT_OFS 8'h18
// Control register strobe bits
`define SRU_CTRL_EN 0
`define SRU_CTRL_DIS 1
`define SRU_CTRL_SEN 2
`define SRU_CTRL_SDIS 3
`define SRU_CTRL_BEEN 4
`define SRU_CTRL_BEDIS 5
// Config fields
`define SRU_CFG_KEY_LSB 0
`define SRU_CFG_KEY_MSB 7
`define SRU_CFG_CYC_LSB 8
`define SRU_CFG_CYC_MSB 23
`define SRU_CFG_OPEN 24
`define SRU_CFG_RESET 32'h00000000
// Status bits; bits 0..6 are error bits
`define SRU_ST_EXP 0
`define SRU_ST_CAU 1
`define SRU_ST_ULREAD 2
`define SRU_ST_ULKEY 3
`define SRU_ST_ULERR 4
`define SRU_ST_MBERR 5
`define SRU_ST_TGTADR 6
`define SRU_ST_CAS 7
`define SRU_ST_IDLE 8
`define SRU_ST_SETUP 9
`define SRU_ST_EN 10
`define SRU_ERR_MASK 8'h7f
// Fast-side map: channels at word index 0..7, unlock word at 0xfc
`define SRU_NCH 8
`define SRU_UNLOCK_OFS 8'hfc
`define SRU_TGT_FLOOR 32'hfffc0000
`endif

// ### hdl/sru_top.v
// Operation
// - Locked or open mechanism chosen by config
// - Locked mode refuses access without prior unlock
// - Unlocked channel relocks after idle interval
// - Only one channel unlocked at once
// - Locked channel access denied, error, flag
// - Expiry relock in locked mode sets an interrupt-capable flag, unless a request is taken that cycle
// - Open mode treats every channel unlocked
// - Each channel holds own target address
// - Remap, check unlock, then start master transfer
// - Read data returned from master to requester
// - Config over APB, data over fast ports
// - One shared clock (ref_clk) for both buses, running after reset
// - Stopped clocks freeze state, resume later
// - Debug mode does not freeze operation
// - Single interrupt request output
// - Target addresses below floor are refused
// - Unlock lasts cycle count or one success
// - Unlock with pending errors aborts, flags
// - Setup mode routes channel address to target
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "sru_regs.vh"
module sru_top (
   input wire ref_clk,
   input wire arst_n,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire fsValid,
   input wire fsWrite,
   input wire [7:0] fsAddr,
   input wire [31:0] fsWdata,
   output reg fsDone,
   output reg fsErr,
   output reg [31:0] fsRdata,
   output reg fmReq,
   output reg fmWrite,
   output reg [31:0] fmAddr,
   output reg [31:0] fmWdata,
   input wire fmAck,
   input wire fmErr,
   input wire [31:0] fmRdata,
   output reg irq
);
   // Transfer states
   localparam ST_IDLE = 2'd0;
   localparam ST_FWD = 2'd1;
   localparam ST_GAP = 2'd2;

   reg [1:0] state_reg; // Fast-side state
   reg en_reg; // Unit enabled
   reg setup_reg; // Setup mode active
   reg berr_reg; // Bus error responses enabled
   reg [31:0] cfg_reg; // Key, cycle count, open bit
   reg [7:0] stat_reg; // Sticky event bits
   reg [7:0] mask_reg; // Interrupt mask
   reg [`SRU_NCH-1:0] chen_reg; // Channel enables
   reg [31:0] tgt_reg [0:`SRU_NCH-1]; // Per-channel remap targets
   reg ulValid_reg; // A channel is unlocked
   reg [2:0] ulChan_reg; // Which channel is unlocked
   reg [15:0] ulTimer_reg; // Remaining unlock cycles
   reg [7:0] statSet; // Hardware set requests
   reg [7:0] statClr; // Software clear requests
   reg [7:0] statNext; // Next sticky value
   wire apbAcc; // Access phase, answer not yet given
   wire apbWr; // Write taken this edge
   wire [2:0] fsChan; // Channel addressed on fast side
   wire fsIsUnlock; // Unlock word addressed
   wire fsIsChan; // Valid channel addressed
   wire chanOpen; // Addressed channel may pass
   wire take; // New fast request taken
   wire errPend; // Error bits pending in status
   integer i;

   // Address in the legal remap region
   function tgtOk;
      input [31:0] a;
      begin
         tgtOk = (a >= `SRU_TGT_FLOOR);
      end
   endfunction

   // Unlock word carries the configured key
   function keyOk;
      input [31:0] d;
      input [31:0] c;
      begin
         keyOk = (d[`SRU_CFG_KEY_MSB:`SRU_CFG_KEY_LSB] == c[`SRU_CFG_KEY_MSB:`SRU_CFG_KEY_LSB]);
      end
   endfunction

   // APB decode, one wait state
   // one clock both sides
   assign apbAcc = psel & penable & ~pready;
   // Write lands on the completing edge only
   assign apbWr = psel & penable & pready & pwrite;
   // Any error bit blocks unlocking
   assign errPend = ((stat_reg & `SRU_ERR_MASK) != 8'h00);

   assign fsChan = fsAddr[4:2];
   assign fsIsUnlock = (fsAddr == `SRU_UNLOCK_OFS);
   assign fsIsChan = (fsAddr[7:5] == 3'd0) && (fsAddr[1:0] == 2'd0);
   assign take = (state_reg == ST_IDLE) & fsValid;
   assign chanOpen = en_reg & chen_reg[fsChan] &
      (cfg_reg[`SRU_CFG_OPEN] | (ulValid_reg & (ulChan_reg == fsChan)));

   // APB answer and read mux
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apbAcc;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (apbAcc) begin
            case (paddr)
               `SRU_CTRL_OFS: prdata <= 32'h00000000;
               `SRU_CFG_OFS: prdata <= cfg_reg;
               `SRU_STAT_OFS: prdata <= {21'h0, en_reg, setup_reg,
                  state_reg == ST_IDLE, stat_reg};
               `SRU_CLR_OFS: prdata <= 32'h00000000;
               `SRU_MASK_OFS: prdata <= {24'h000000, mask_reg};
               `SRU_CHEN_OFS: prdata <= {24'h000000, chen_reg};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Control, config, mask and enable registers
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         en_reg <= 1'b0;
         setup_reg <= 1'b0;
         berr_reg <= 1'b0;
         cfg_reg <= `SRU_CFG_RESET;
         mask_reg <= 8'h00;
         chen_reg <= 8'h00;
      end else if (apbWr) begin
         case (paddr)
            `SRU_CTRL_OFS: begin
               if (pwdata[`SRU_CTRL_EN]) en_reg <= 1'b1;
               if (pwdata[`SRU_CTRL_DIS]) en_reg <= 1'b0;
               if (pwdata[`SRU_CTRL_SEN]) setup_reg <= 1'b1;
               if (pwdata[`SRU_CTRL_SDIS]) setup_reg <= 1'b0;
               if (pwdata[`SRU_CTRL_BEEN]) berr_reg <= 1'b1;
               if (pwdata[`SRU_CTRL_BEDIS]) berr_reg <= 1'b0;
            end
            `SRU_CFG_OFS: cfg_reg <= {7'h00, pwdata[24:0]};
            `SRU_MASK_OFS: mask_reg <= pwdata[7:0];
            `SRU_CHEN_OFS: chen_reg <= pwdata[7:0];
            default: cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Sticky status: set beats clear
   always @* begin
      statClr = (apbWr && paddr == `SRU_CLR_OFS) ? pwdata[7:0] : 8'h00;
      statSet = 8'h00;
      if (ulValid_reg && !take && ulTimer_reg == 16'h0000 && !cfg_reg[`SRU_CFG_OPEN])
         statSet[`SRU_ST_EXP] = 1'b1;
      if (take) begin
         if (fsIsUnlock) begin
            if (!fsWrite)
               statSet[`SRU_ST_ULREAD] = 1'b1;
            else if (errPend)
               statSet[`SRU_ST_ULERR] = 1'b1;
            else if (!keyOk(fsWdata, cfg_reg))
               statSet[`SRU_ST_ULKEY] = 1'b1;
         end else if (fsIsChan && setup_reg) begin
            if (fsWrite && !tgtOk(fsWdata))
               statSet[`SRU_ST_TGTADR] = 1'b1;
         end else if (!fsIsChan || !chanOpen) begin
            statSet[`SRU_ST_CAU] = 1'b1;
         end
      end
      if (state_reg == ST_FWD && fmAck) begin
         if (fmErr)
            statSet[`SRU_ST_MBERR] = 1'b1;
         else
            statSet[`SRU_ST_CAS] = 1'b1;
      end
      statNext = (stat_reg & ~statClr) | statSet;
   end

   // Status register and interrupt line
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_reg <= 8'h00;
         irq <= 1'b0;
      end else begin
         stat_reg <= statNext;
         irq <= |(statNext & mask_reg);
      end
   end

   // Unlock window
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ulValid_reg <= 1'b0;
         ulChan_reg <= 3'd0;
         ulTimer_reg <= 16'h0000;
      end else begin
         if (ulValid_reg && ulTimer_reg != 16'h0000)
            ulTimer_reg <= ulTimer_reg - 16'h0001;
         if (ulValid_reg && ulTimer_reg == 16'h0000)
            ulValid_reg <= 1'b0;
         if (take && fsIsUnlock && fsWrite && !errPend && keyOk(fsWdata, cfg_reg) &&
            fsWdata[15:8] < `SRU_NCH) begin
            ulValid_reg <= 1'b1;
            ulChan_reg <= fsWdata[10:8];
            ulTimer_reg <= cfg_reg[`SRU_CFG_CYC_MSB:`SRU_CFG_CYC_LSB];
         end else if (state_reg == ST_FWD && fmAck && !fmErr && !cfg_reg[`SRU_CFG_OPEN]) begin
            ulValid_reg <= 1'b0;
         end
      end
   end

   // Target table
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (i = 0; i < `SRU_NCH; i = i + 1)
            tgt_reg[i] <= `SRU_TGT_FLOOR;
      end else if (take && fsIsChan && setup_reg && fsWrite && tgtOk(fsWdata)) begin
         tgt_reg[fsChan] <= fsWdata;
      end
   end

   // Fast-side transfer machine
   // all state in flops, frozen with clock
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         fsDone <= 1'b0;
         fsErr <= 1'b0;
         fsRdata <= 32'h00000000;
         fmReq <= 1'b0;
         fmWrite <= 1'b0;
         fmAddr <= 32'h00000000;
         fmWdata <= 32'h00000000;
      end else begin
         fsDone <= 1'b0;
         fsErr <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (fsValid) begin
                  state_reg <= ST_GAP;
                  fsDone <= 1'b1;
                  fsRdata <= 32'h00000000;
                  if (fsIsUnlock) begin
                     fsErr <= berr_reg & ~fsWrite;
                  end else if (fsIsChan && setup_reg) begin
                     fsRdata <= tgt_reg[fsChan];
                  end else if (fsIsChan && chanOpen) begin
                     state_reg <= ST_FWD;
                     fsDone <= 1'b0;
                     fmReq <= 1'b1;
                     fmWrite <= fsWrite;
                     fmAddr <= tgt_reg[fsChan];
                     fmWdata <= fsWdata;
                  end else begin
                     fsErr <= berr_reg;
                  end
               end
            end
            ST_FWD: begin
               if (fmAck) begin
                  fmReq <= 1'b0;
                  fsDone <= 1'b1;
                  fsErr <= berr_reg & fmErr;
                  fsRdata <= fmRdata;
                  state_reg <= ST_GAP;
               end
            end
            ST_GAP: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

// ### tb/sru_top_assertions.sv
`timescale 1ns/1ps
module sru_chk (
   input wire ref_clk,
   input wire arst_n,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire fsValid,
   input wire fsWrite,
   input wire [31:0] fsWdata,
   input wire fsDone,
   input wire fsErr,
   input wire [31:0] fsRdata,
   input wire fmReq,
   input wire fmWrite,
   input wire [31:0] fmWdata,
   input wire [31:0] fmAddr,
   input wire fmAck,
   input wire [31:0] fmRdata
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_rdy; psel && penable && !pready |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("apb no ready");
   property p_rdyq; pready |=> !pready; endproperty
   a_rdyq: assert property (p_rdyq) else $error("ready too long");
   property p_fwd; fmReq && fmAck |=> fsDone && fsRdata == $past(fmRdata); endproperty
   a_fwd: assert property (p_fwd) else $error("read data lost");
   property p_hold; fmReq && !fmAck |=> fmReq && $stable(fmAddr); endproperty
   a_hold: assert property (p_hold) else $error("master req dropped");
   property p_drop; fmReq && fmAck |=> !fmReq; endproperty
   a_drop: assert property (p_drop) else $error("master req kept");
   property p_floor; fmReq |-> fmAddr >= 32'hfffc0000; endproperty
   a_floor: assert property (p_floor) else $error("target below floor");
   property p_err; fsErr |-> fsDone; endproperty
   a_err: assert property (p_err) else $error("error without done");
   property p_done; fsDone |=> !fsDone; endproperty
   a_done: assert property (p_done) else $error("done too long");
   property p_start; $rose(fmReq) |-> fsValid; endproperty
   a_start: assert property (p_start) else $error("master req unasked");
   property p_fwr; $rose(fmReq) |-> fmWrite == fsWrite && fmWdata == fsWdata; endproperty
   a_fwr: assert property (p_fwr) else $error("master dir or data wrong");
endmodule
bind sru_top sru_chk chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pready(pready), .fsValid(fsValid), .fsWrite(fsWrite), .fsWdata(fsWdata), .fsDone(fsDone),
   .fsErr(fsErr), .fsRdata(fsRdata), .fmReq(fmReq), .fmWrite(fmWrite), .fmWdata(fmWdata),
   .fmAddr(fmAddr), .fmAck(fmAck), .fmRdata(fmRdata));

// ### tb/sru_far_model.sv
`timescale 1ns/1ps
module sru_far_model (
   input wire ref_clk,
   input wire arst_n,
   input wire fmReq,
   input wire [31:0] fmAddr,
   input wire [3:0] lag,
   input wire errOn,
   output logic fmAck,
   output logic fmErr,
   output logic [31:0] fmRdata
);
   logic [3:0] cnt;
   // Target slave: answers after lag cycles, data scrambled from address
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= '0;
         fmAck <= '0;
         fmErr <= '0;
         fmRdata <= '0;
      end else if (fmReq && !fmAck && cnt >= lag) begin
         fmAck <= 1'h1;
         fmErr <= errOn;
         fmRdata <= fmAddr ^ 32'h5a5a5a5a;
      end else begin
         // Released data toggles so stale values never pass
         fmAck <= 1'h0;
         fmErr <= 1'h0;
         fmRdata <= ~fmRdata;
         cnt <= (fmReq && !fmAck) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// ### tb/sru_top_tb.sv
`timescale 1ns/1ps
`include "sru_regs.vh"
module sru_top_tb;
   logic ref_clk = '0, arst_n = '0, psel = '0, penable = '0, pwrite = '0;
   logic fsValid = '0, fsWrite = '0, errOn = '0;
   logic [7:0] paddr = '0, fsAddr = '0;
   logic [31:0] pwdata = '0, fsWdata = '0, prdata, fsRdata, fmAddr, fmWdata, fmRdata, rd;
   logic pready, pslverr, fsDone, fsErr, fmReq, fmWrite, fmAck, fmErr, irq, er;
   logic [3:0] lag = '0;
   int n_mismatch = 0;
   int check_count = 0;
   always #2.5 ref_clk = ~ref_clk;
   sru_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fsValid(fsValid), .fsWrite(fsWrite), .fsAddr(fsAddr), .fsWdata(fsWdata), .fsDone(fsDone),
      .fsErr(fsErr), .fsRdata(fsRdata), .fmReq(fmReq), .fmWrite(fmWrite), .fmAddr(fmAddr),
      .fmWdata(fmWdata), .fmAck(fmAck), .fmErr(fmErr), .fmRdata(fmRdata), .irq(irq));
   sru_far_model far_u (.ref_clk(ref_clk), .arst_n(arst_n), .fmReq(fmReq), .fmAddr(fmAddr),
      .lag(lag), .errOn(errOn), .fmAck(fmAck), .fmErr(fmErr), .fmRdata(fmRdata));
   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   // APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (pready === 1'h1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Fast-slave request, held until done
   // clock never stopped, request always finished
   task automatic fs(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      fsValid <= 1'h1;
      fsWrite <= w;
      fsAddr <= a;
      fsWdata <= d;
      for (i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         if (fsDone === 1'h1) break;
      end
      if (i == 40) begin
         n_mismatch++;
         close_out();
      end
      rd = fsRdata;
      er = fsErr;
      fsValid <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic st(input logic [31:0] e, input string m);
      apb(1'h0, `SRU_STAT_OFS, 32'h0);
      chk(rd & 32'h7f, e, m);
   endtask
   task automatic clr();
      apb(1'h1, `SRU_CLR_OFS, 32'hff);
   endtask
   task automatic t_regs();
      apb(1'h0, `SRU_CFG_OFS, 32'h0);
      chk(rd, 32'h0, "cfg reset");
      apb(1'h0, `SRU_STAT_OFS, 32'h0);
      chk(rd, 32'h100, "idle at reset");
      apb(1'h1, 8'h20, 32'h1);
      chk(er, 1'h1, "unmapped");
      $display("regs done");
   endtask
   task automatic t_setup();
      apb(1'h1, `SRU_CTRL_OFS, 32'h15);
      fs(1'h1, 8'h00, 32'hfffc0100);
      fs(1'h1, 8'h04, 32'h00001000);
      fs(1'h0, 8'h00, 32'h0);
      chk(rd, 32'hfffc0100, "target");
      st(32'h40, "bad target");
      clr();
      apb(1'h1, `SRU_CTRL_OFS, 32'h8);
      apb(1'h1, `SRU_CHEN_OFS, 32'h3);
      $display("setup done");
   endtask
   task automatic t_open();
      apb(1'h1, `SRU_CFG_OFS, 32'h01000000);
      lag <= 4'h3;
      fs(1'h0, 8'h00, 32'h0);
      chk(rd, 32'hfffc0100 ^ 32'h5a5a5a5a, "open read");
      fs(1'h0, 8'h04, 32'h0);
      chk(rd, 32'hfffc0000 ^ 32'h5a5a5a5a, "ch1 read");
      errOn <= 1'h1;
      fs(1'h1, 8'h00, 32'h1);
      chk(er, 1'h1, "master err");
      st(32'h20, "master err flag");
      errOn <= 1'h0;
      lag <= 4'h0;
      clr();
      $display("open done");
   endtask
   task automatic t_lock();
      apb(1'h1, `SRU_CFG_OFS, 32'h000008a5);
      fs(1'h0, 8'h00, 32'h0);
      chk(er, 1'h1, "locked deny");
      st(32'h02, "deny flag");
      clr();
      fs(1'h1, 8'hfc, 32'h5a);
      st(32'h08, "bad key");
      fs(1'h1, 8'hfc, 32'ha5);
      st(32'h18, "unlock abort");
      clr();
      fs(1'h1, 8'hfc, 32'h1a5);
      fs(1'h1, 8'hfc, 32'ha5);
      fs(1'h0, 8'h04, 32'h0);
      chk(er, 1'h1, "old relocked");
      repeat (12) @(posedge ref_clk);
      clr();
      fs(1'h1, 8'hfc, 32'ha5);
      fs(1'h0, 8'h00, 32'h0);
      chk(rd, 32'hfffc0100 ^ 32'h5a5a5a5a, "unlocked read");
      fs(1'h0, 8'h00, 32'h0);
      chk(er, 1'h1, "one access only");
      clr();
      $display("lock done");
   endtask
   task automatic t_exp();
      apb(1'h1, `SRU_MASK_OFS, 32'h1);
      fs(1'h1, 8'hfc, 32'ha5);
      repeat (20) @(posedge ref_clk);
      st(32'h01, "expiry");
      chk(irq, 1'h1, "irq on");
      clr();
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'h0, "irq off");
      $display("expiry done");
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'h1;
      t_regs();
      t_setup();
      t_open();
      t_lock();
      t_exp();
      close_out();
   end
endmodule
